// >>> pinmux_pkg.sv
// package for the pin function and sink drive selection block
// assumes one 25 MHz clock and a byte-wide register port
package pinmux_pkg;
   // =====================================================
   // register indices on the port
   localparam int          NUM_REGS   = 12;
   localparam logic [3:0]  OFS_A_SINK = 4'h0;
   localparam logic [3:0]  OFS_C_SINK = 4'h1;
   localparam logic [3:0]  OFS_D_SINK = 4'h2;
   localparam logic [3:0]  OFS_A_SEL0 = 4'h3;
   localparam logic [3:0]  OFS_A_SEL1 = 4'h4;
   localparam logic [3:0]  OFS_B_SEL0 = 4'h5;
   localparam logic [3:0]  OFS_B_SEL1 = 4'h6;
   localparam logic [3:0]  OFS_C_SEL0 = 4'h7;
   localparam logic [3:0]  OFS_C_SEL1 = 4'h8;
   localparam logic [3:0]  OFS_D_SEL  = 4'h9;
   localparam logic [3:0]  OFS_IN_SER = 4'hA;
   localparam logic [3:0]  OFS_IN_TMR = 4'hB;
   // =====================================================
   // implemented bits and reset value
   localparam logic [7:0]  MASK_A_SINK = 8'h9F;
   localparam logic [7:0]  MASK_D_SINK = 8'h0F;
   localparam logic [7:0]  MASK_A_SEL1 = 8'hC3;
   localparam logic [7:0]  MASK_IN_TMR = 8'h0F;
   localparam logic [7:0]  MASK_FULL   = 8'hFF;
   localparam logic [7:0]  RESET_VAL   = 8'h00;
   // =====================================================
   // field positions (index of the two-bit field)
   localparam int          FLD_A3 = 3;
   localparam int          FLD_A2 = 2;
   localparam int          FLD_A1 = 1;
   localparam int          FLD_A0 = 0;
   localparam int          FLD_A7 = 3;
   localparam int          FLD_A4 = 0;
   localparam int          FLD_RX = 0;
   localparam int          FLD_SCK = 1;
   localparam int          FLD_SDI = 2;
   localparam int          FLD_SCS = 3;
   localparam int          FLD_PTCK = 1;
   // =====================================================
   // field codes
   typedef enum logic [1:0] {
      SEL_00 = 2'h0,
      SEL_01 = 2'h1,
      SEL_10 = 2'h2,
      SEL_11 = 2'h3
   } sel_t;
   // =====================================================
   // peripheral drive toward the pins
   typedef struct packed {
      logic sdo;
      logic sdo_oe;
      logic sck;
      logic sck_oe;
      logic serial_chip_select;
      logic scs_oe;
      logic sda;
      logic sda_oe;
      logic tx;
      logic tx_oe;
   } periph_drv_t;
   // peripheral inputs picked from the pins
   typedef struct packed {
      logic uart_rx;
      logic sck;
      logic sdi;
      logic serial_chip_select;
      logic periodic_timer0_ext_clock;
   } periph_in_t;
endpackage : pinmux_pkg

// >>> pin_function_and_sink_select.sv
// pin function routing and sink drive selection, registers on a byte port
// assumes gpio and peripheral signals on ref_clk_in, pins asynchronous
`timescale 1ns/10ps
`default_nettype none
module pin_function_and_sink_select #(
   parameter int ADDR_W = 4
) (
   input  wire logic                    ref_clk_in,
   input  wire logic                    nrst_in,
   input  wire logic [ADDR_W-1:0]       addr_in,
   input  wire logic [7:0]              wdata_in,
   input  wire logic                    wr_in,
   input  wire logic                    rd_in,
   output logic      [7:0]              rdata_out,
   input  wire logic [7:0]              pa_gpio_in,
   input  wire logic [7:0]              pa_dir_in,
   input  wire pinmux_pkg::periph_drv_t periph_in,
   input  wire logic [7:0]              pa_pin_in,
   input  wire logic [7:0]              pc_pin_in,
   input  wire logic [3:0]              pd_pin_in,
   output logic      [7:0]              pa_pin_out,
   output logic      [7:0]              pa_pin_oe_out,
   output logic      [7:0]              pa_analog_out,
   output logic      [3:0]              pb_touch_out,
   output logic      [7:0]              pa_sink_out,
   output logic      [7:0]              pc_sink_out,
   output logic      [3:0]              pd_sink_out,
   output logic      [7:0]              pc_sel_out,
   output logic      [15:0]             pcd_sel_out,
   output pinmux_pkg::periph_in_t       periph_out
);
   import pinmux_pkg::*;

   // index decode reads addr_in[3:0], so narrower buses cannot work
   if (ADDR_W < 4) begin : g_addr_w_check
      $error("ADDR_W must cover twelve registers");
   end

   // =====================================================
   // state
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [7:0]               rdata;
      logic [7:0]               a_s1, a_s2, c_s1, c_s2;
      logic [3:0]               d_s1, d_s2;
      logic [7:0]               pa_o, pa_oe, pa_an;
      logic [3:0]               pb_key;
      periph_in_t               pin;
   } state_t;

   state_t s_q, s_d;

   // =====================================================
   // helpers
   function automatic logic [7:0] wmask(input logic [3:0] idx);
      unique case (idx)
         OFS_A_SINK: wmask = MASK_A_SINK;
         OFS_D_SINK: wmask = MASK_D_SINK;
         OFS_A_SEL1: wmask = MASK_A_SEL1;
         OFS_IN_TMR: wmask = MASK_IN_TMR;
         default:    wmask = MASK_FULL;
      endcase
   endfunction : wmask

   function automatic sel_t fld(input logic [7:0] r, input int i);
      fld = sel_t'(r[2*i +: 2]);
   endfunction : fld

   logic       hit;
   logic [3:0] idx;
   assign idx = addr_in[3:0];
   assign hit = (addr_in < ADDR_W'(NUM_REGS));

   // =====================================================
   // next state
   always_comb begin
      logic [7:0] a0, a1, b0, i0, i1;
      {a0, a1, b0, i0, i1} = '0;
      s_d = s_q;
      // register port, unmapped writes ignored and reads zero
      if (wr_in && hit) begin
         s_d.regs[idx] = wdata_in & wmask(idx);
      end
      s_d.rdata = (rd_in && hit) ? s_q.regs[idx] : 8'h00;
      // pin inputs double synchronised before use
      s_d.a_s1 = pa_pin_in;
      s_d.a_s2 = s_q.a_s1;
      s_d.c_s1 = pc_pin_in;
      s_d.c_s2 = s_q.c_s1;
      s_d.d_s1 = pd_pin_in;
      s_d.d_s2 = s_q.d_s1;
      // routing decodes from the new field values so the pad stage
      // shows a write one cycle after it
      a0 = s_d.regs[OFS_A_SEL0];
      a1 = s_d.regs[OFS_A_SEL1];
      b0 = s_d.regs[OFS_B_SEL0];
      i0 = s_d.regs[OFS_IN_SER];
      i1 = s_d.regs[OFS_IN_TMR];
      // gpio default: direction 1 means input
      s_d.pa_o  = pa_gpio_in;
      s_d.pa_oe = ~pa_dir_in;
      s_d.pa_an = 8'h00;
      unique case (fld(a0, FLD_A3))
         SEL_01: {s_d.pa_o[3], s_d.pa_oe[3]} = {periph_in.sda, periph_in.sda_oe};
         SEL_10: {s_d.pa_o[3], s_d.pa_oe[3]} = {periph_in.tx, periph_in.tx_oe};
         SEL_11: {s_d.pa_oe[3], s_d.pa_an[3]} = 2'b01;
         SEL_00: ;
      endcase
      if (fld(a0, FLD_A2) == SEL_01) begin
         {s_d.pa_o[2], s_d.pa_oe[2]} = {periph_in.serial_chip_select, periph_in.scs_oe};
      end
      unique case (fld(a0, FLD_A1))
         SEL_01: {s_d.pa_o[1], s_d.pa_oe[1]} = {periph_in.sda, periph_in.sda_oe};
         SEL_10: {s_d.pa_o[1], s_d.pa_oe[1]} = {periph_in.tx, periph_in.tx_oe};
         SEL_11: {s_d.pa_oe[1], s_d.pa_an[1]} = 2'b01;
         SEL_00: ;
      endcase
      // other codes keep gpio plus the timer clock input path
      if (fld(a0, FLD_A0) == SEL_01) begin
         {s_d.pa_o[0], s_d.pa_oe[0]} = {periph_in.sdo, periph_in.sdo_oe};
      end
      unique case (fld(a1, FLD_A7))
         SEL_01: {s_d.pa_o[7], s_d.pa_oe[7]} = {periph_in.sck, periph_in.sck_oe};
         SEL_10: {s_d.pa_o[7], s_d.pa_oe[7]} = {periph_in.tx, periph_in.tx_oe};
         SEL_00, SEL_11: ;
      endcase
      unique case (fld(a1, FLD_A4))
         SEL_01: {s_d.pa_o[4], s_d.pa_oe[4]} = {periph_in.sck, periph_in.sck_oe};
         SEL_10: {s_d.pa_o[4], s_d.pa_oe[4]} = {periph_in.tx, periph_in.tx_oe};
         SEL_11: {s_d.pa_oe[4], s_d.pa_an[4]} = 2'b01;
         SEL_00: ;
      endcase
      for (int k = 0; k < 4; k++) begin
         s_d.pb_key[k] = (fld(b0, k) == SEL_01);
      end
      // input source selection
      unique case (fld(i0, FLD_RX))
         SEL_01:         s_d.pin.uart_rx = s_q.d_s2[0];
         SEL_10:         s_d.pin.uart_rx = s_q.a_s2[4];
         SEL_00, SEL_11: s_d.pin.uart_rx = s_q.a_s2[3];
      endcase
      s_d.pin.sck = (fld(i0, FLD_SCK) == SEL_01) ?
                    s_q.a_s2[4] : s_q.a_s2[7];
      s_d.pin.sdi = (fld(i0, FLD_SDI) == SEL_01) ?
                    s_q.a_s2[1] : s_q.a_s2[3];
      s_d.pin.serial_chip_select = (fld(i0, FLD_SCS) == SEL_01) ?
                    s_q.c_s2[4] : s_q.a_s2[2];
      s_d.pin.periodic_timer0_ext_clock = (fld(i1, FLD_PTCK) == SEL_01) ?
                      s_q.c_s2[2] : s_q.a_s2[0];
   end

   // =====================================================
   // registers
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // =====================================================
   // outputs, all from flip-flops
   assign rdata_out     = s_q.rdata;
   assign pa_pin_out    = s_q.pa_o;
   assign pa_pin_oe_out = s_q.pa_oe;
   assign pa_analog_out = s_q.pa_an;
   assign pb_touch_out  = s_q.pb_key;
   assign pa_sink_out   = s_q.regs[OFS_A_SINK];
   assign pc_sink_out   = s_q.regs[OFS_C_SINK];
   assign pd_sink_out   = s_q.regs[OFS_D_SINK][3:0];
   assign pc_sel_out    = s_q.regs[OFS_B_SEL1];
   assign pcd_sel_out   = {s_q.regs[OFS_C_SEL1], s_q.regs[OFS_C_SEL0]};
   assign periph_out    = s_q.pin;

   // =====================================================
   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   chk_a_sink_gap: assert property (
      rd_in && addr_in == ADDR_W'(OFS_A_SINK) |=> rdata_out[6:5] == 2'b00)
      else $error("port A sink bits 6..5 not zero");
   chk_d_sink_top: assert property (
      rd_in && addr_in == ADDR_W'(OFS_D_SINK) |=> rdata_out[7:4] == 4'h0)
      else $error("port D sink upper bits not zero");
   chk_a_sel1_gap: assert property (
      rd_in && addr_in == ADDR_W'(OFS_A_SEL1) |=> rdata_out[5:2] == 4'h0)
      else $error("port A high select gap not zero");
   chk_sink_write: assert property (
      wr_in && addr_in == ADDR_W'(OFS_A_SINK)
      |=> pa_sink_out == ($past(wdata_in) & MASK_A_SINK))
      else $error("port A sink write lost");
   chk_c_sink_hold: assert property (
      !(wr_in && addr_in == ADDR_W'(OFS_C_SINK)) |=> $stable(pc_sink_out))
      else $error("port C sink changed without write");
   chk_a0_sdo_route: assert property (
      wr_in && addr_in == ADDR_W'(OFS_A_SEL0) && wdata_in[1:0] == 2'b01
      |=> pa_pin_out[0] == $past(periph_in.sdo)
          && pa_pin_oe_out[0] == $past(periph_in.sdo_oe))
      else $error("pin A0 not routed to data out");
   chk_a3_uart_route: assert property (
      s_q.regs[OFS_A_SEL0][7:6] == 2'b10 && !wr_in
      |=> pa_pin_oe_out[3] == $past(periph_in.tx_oe))
      else $error("pin A3 not driven by uart");
   chk_a4_key_route: assert property (
      s_q.regs[OFS_A_SEL1][1:0] == 2'b11 && !wr_in
      |=> pa_analog_out[4] && !pa_pin_oe_out[4])
      else $error("pin A4 not released to touch key");
   chk_b_touch_sel: assert property (
      s_q.regs[OFS_B_SEL0][1:0] == 2'b10 && !wr_in |=> !pb_touch_out[0])
      else $error("pin B0 touch key on wrong code");
   chk_rx_source: assert property (
      s_q.regs[OFS_IN_SER][1:0] == 2'b01 && !wr_in
      |=> periph_out.uart_rx == $past(s_q.d_s2[0]))
      else $error("uart receive not taken from D0");
   chk_sck_source: assert property (
      s_q.regs[OFS_IN_SER][3:2] == 2'b00 && !wr_in
      |=> periph_out.sck == $past(s_q.a_s2[7]))
      else $error("serial clock not taken from A7");
   chk_sdi_source: assert property (
      s_q.regs[OFS_IN_SER][5:4] == 2'b01 && !wr_in
      |=> periph_out.sdi == $past(s_q.a_s2[1]))
      else $error("serial data not taken from A1");
   chk_a7_sck_route: assert property (
      s_q.regs[OFS_A_SEL1][7:6] == 2'b01 && !wr_in
      |=> pa_pin_out[7] == $past(periph_in.sck))
      else $error("pin A7 not routed to serial clock");

   cov_a1_key: cover property (
      wr_in && addr_in == ADDR_W'(OFS_A_SEL0) && wdata_in[3:2] == 2'b11
      ##1 pa_analog_out[1]);
   cov_rx_a4: cover property (
      wr_in && addr_in == ADDR_W'(OFS_IN_SER) && wdata_in[1:0] == 2'b10);
   cov_rd_after_wr: cover property (
      wr_in && addr_in == ADDR_W'(OFS_C_SINK)
      ##1 rd_in && addr_in == ADDR_W'(OFS_C_SINK));
endmodule : pin_function_and_sink_select
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the pin function and sink drive select block
// assumes pinmux_pkg is compiled first; the bench drives every port itself
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import pinmux_pkg::*;
   logic            ref_clk_in;
   logic            nrst_in;
   logic [3:0]      addr;
   logic [7:0]      wdata;
   logic            wr;
   logic            rd;
   logic [7:0]      rdata;
   logic [7:0]      pa_gpio;
   logic [7:0]      pa_dir;
   periph_drv_t     periph;
   logic [7:0]      pa_pin;
   logic [7:0]      pc_pin;
   logic [3:0]      pd_pin;
   logic [7:0]      pa_out;
   logic [7:0]      pa_oe;
   logic [7:0]      pa_an;
   logic [3:0]      pb_touch;
   logic [7:0]      pa_sink;
   logic [7:0]      pc_sink;
   logic [3:0]      pd_sink;
   logic [7:0]      pc_sel;
   logic [15:0]     pcd_sel;
   periph_in_t      pin_pick;
   logic [7:0]      rv;
   int              n_fail;
   int              checked;
   // readback after writing all ones (FC to index 11); index 12 is unmapped
   logic [7:0]      mask   [13] = '{8'h9F, 8'hFF, 8'h0F, 8'hFF, 8'hC3,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0C, 8'h00};
   // per select code: pins A7,A4..A0 with fixed peripheral pattern
   logic [7:0]      exp_v  [4] = '{8'h00, 8'h9B, 8'h00, 8'h00};
   logic [7:0]      exp_o  [4] = '{8'h00, 8'h05, 8'h9A, 8'h00};
   logic [7:0]      exp_a  [4] = '{8'h00, 8'h00, 8'h00, 8'h1A};
   // {uart_rx,sck,sdi,scs,periodic_timer0_ext_clock} for pins A=8C, C=04, D=0
   logic [4:0]      exp_in [4] = '{5'h1E, 5'h01, 5'h0E, 5'h1E};

   pin_function_and_sink_select pin_function_and_sink_select_inst (
      .ref_clk_in    (ref_clk_in),
      .nrst_in       (nrst_in),
      .addr_in       (addr),
      .wdata_in      (wdata),
      .wr_in         (wr),
      .rd_in         (rd),
      .rdata_out     (rdata),
      .pa_gpio_in    (pa_gpio),
      .pa_dir_in     (pa_dir),
      .periph_in     (periph),
      .pa_pin_in     (pa_pin),
      .pc_pin_in     (pc_pin),
      .pd_pin_in     (pd_pin),
      .pa_pin_out    (pa_out),
      .pa_pin_oe_out (pa_oe),
      .pa_analog_out (pa_an),
      .pb_touch_out  (pb_touch),
      .pa_sink_out   (pa_sink),
      .pc_sink_out   (pc_sink),
      .pd_sink_out   (pd_sink),
      .pc_sel_out    (pc_sel),
      .pcd_sel_out   (pcd_sel),
      .periph_out    (pin_pick)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   // ==========================================================
   // access tasks
   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   // settles one ns past the taking edge so results can be sampled
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge ref_clk_in);
      wr    <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge ref_clk_in);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // ==========================================================
   // main sequence
   initial begin
      n_fail = 0;
      checked = 0;
      nrst_in = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      pa_gpio = 8'h00;
      pa_dir = 8'hFF;
      // sdo 1/1, sck 1/0, scs 0/1, sda 1/0, tx 0/1 keep sources apart
      periph = 10'h399;
      pa_pin = 8'h8C;
      pc_pin = 8'h04;
      pd_pin = 4'h0;
      repeat (3) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         reg_rd(4'(i), rv);
         check("reset value", 16'h0000, 16'(rv));
      end
      check("sink c at reset", 16'h0000, 16'(pc_sink));
      $display("test reset values done");
      // reserved timer select bits stay zero on the write
      for (int i = 0; i < 13; i++) begin
         reg_wr(4'(i), (i == 11) ? 8'hFC : 8'hFF);
      end
      check("sink a", 16'h009F, 16'(pa_sink));
      check("sink c", 16'h00FF, 16'(pc_sink));
      check("sink d", 16'h000F, 16'(pd_sink));
      check("b sel high", 16'h00FF, 16'(pc_sel));
      check("c sel", 16'hFFFF, pcd_sel);
      for (int i = 0; i < 13; i++) begin
         reg_rd(4'(i), rv);
         check("readback", 16'(mask[i]), 16'(rv));
      end
      @(posedge ref_clk_in);
      #1;
      check("read data idle", 16'h0000, 16'(rdata));
      for (int i = 0; i < 12; i++) reg_wr(4'(i), 8'h00);
      $display("test register access done");
      // selects are written before the peripheral pattern matters
      for (int c = 0; c < 4; c++) begin
         reg_wr(OFS_A_SEL1, {2'(c), 4'h0, 2'(c)});
         reg_wr(OFS_A_SEL0, {4{2'(c)}});
         check("pin value", 16'(exp_v[c]), 16'(pa_out));
         check("pin enable", 16'(exp_o[c]), 16'(pa_oe));
         check("pin analog", 16'(exp_a[c]), 16'(pa_an));
         reg_wr(OFS_B_SEL0, {4{2'(c)}});
         check("touch", (c == 1) ? 16'h000F : 16'h0000,
               16'(pb_touch));
      end
      @(posedge ref_clk_in);
      periph <= '0;
      reg_wr(OFS_A_SEL0, 8'h00);
      reg_wr(OFS_A_SEL1, 8'h00);
      @(posedge ref_clk_in);
      pa_gpio <= 8'hA5;
      pa_dir  <= 8'h3C;
      @(posedge ref_clk_in);
      #1;
      check("gpio value", 16'h00A5, 16'(pa_out));
      check("gpio enable", 16'h00C3, 16'(pa_oe));
      $display("test output routing done");
      @(posedge ref_clk_in);
      pa_dir <= 8'hFF;
      for (int c = 0; c < 4; c++) begin
         reg_wr(OFS_IN_SER, {4{2'(c)}});
         reg_wr(OFS_IN_TMR, {4'h0, 2'(c), 2'b00});
         // three-flop input path, one spare cycle
         repeat (4) @(posedge ref_clk_in);
         #1;
         check("input pick", 16'(exp_in[c]), 16'(pin_pick));
      end
      $display("test input selection done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
